// [logic/hdf_regs.svh]
// constants for the humidity and temperature read-out link
// Overview of operation
// - master fetches with target address plus read
// - sensor acknowledges its address on a fetch
// - bytes flow until master sends NACK, STOP
// - bytes one, two: status bits, 14-bit humidity
// - bytes three, four: temperature, low bits dropped
// - master may stop after second byte
// - master checks status code for freshness
// - status 00 means data not yet fetched
// - status 01 means data already fetched
// - before first measurement status reads 01
// - humidity percent is code/(2^14-1)*100
// - temperature is code/(2^14-1)*165-40
// - address plus write triggers one conversion
// - new data latched at measurement end
// - sensor answers only address 44 hex
// - data is 14 bits, MSB first
`ifndef HDF_REGS_SVH
`define HDF_REGS_SVH
`define HDF_TARGET_ADDR  7'h44
`define HDF_DIR_READ     1'b1
`define HDF_DIR_WRITE    1'b0
`define HDF_STAT_FRESH   2'h0
`define HDF_STAT_STALE   2'h1
`define HDF_PAD_BYTE     8'hff
`define HDF_SYS_HZ       25000000
`define HDF_SCL_HZ       100000
`define HDF_QUARTER_CYC  ((`HDF_SYS_HZ + 4 * `HDF_SCL_HZ - 1) / (4 * `HDF_SCL_HZ))
`define HDF_CODE_FULL    16383
`define HDF_HUM_SPAN     100
`define HDF_TEMP_SPAN    165
`define HDF_TEMP_OFS     40
`endif

// [logic/hdf_pkg.sv]
// types shared by both ends of the read-out link
package hdf_pkg;
   typedef logic [1:0]  hdf_status_type;
   typedef logic [13:0] hdf_code_type;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_ADDR = 5'h02,
      S_ACK  = 5'h04,
      S_TX   = 5'h08,
      S_RACK = 5'h10
   } hdf_sens_state_type;
   typedef enum logic [6:0] {
      M_IDLE  = 7'h01,
      M_START = 7'h02,
      M_ADDR  = 7'h04,
      M_AACK  = 7'h08,
      M_RDATA = 7'h10,
      M_MACK  = 7'h20,
      M_STOP  = 7'h40
   } hdf_mst_state_type;
endpackage

// [logic/hdf_if.sv]
// open-drain two-wire link joining master and sensor
`timescale 1ns/100ps
`default_nettype none
interface hdf_if;
   logic scl_m_out;
   logic scl_m_oe;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_s_out;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // pull-ups: a line is low only while some end drives low
   assign scl = ~(scl_m_oe & ~scl_m_out);
   assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));
   modport sensor (input scl, input sda, output sda_s_out, output sda_s_oe);
   modport master (input sda, output scl_m_out, output scl_m_oe,
                   output sda_m_out, output sda_m_oe);
endinterface
`default_nettype wire

// [logic/hdf_sensor.sv]
// sensor end: two-wire target returning status, humidity, temperature
`timescale 1ns/100ps
`default_nettype none
`include "hdf_regs.svh"
module hdf_sensor (
   input  wire logic                   SYS_CLK,
   input  wire logic                   RESET,
   hdf_if.sensor                       LINK,
   output var  logic                   MEAS_START,
   output var  logic                   MEAS_BUSY,
   input  wire logic                   MEAS_DONE,
   input  wire hdf_pkg::hdf_code_type  HUM_CODE,
   input  wire hdf_pkg::hdf_code_type  TEMP_CODE,
   output var  logic                   DATA_FRESH
);
   import hdf_pkg::*;

   logic               scl_s1_reg;
   logic               scl_s2_reg;
   logic               scl_s3_reg;
   logic               sda_s1_reg;
   logic               sda_s2_reg;
   logic               sda_s3_reg;
   logic               scl_rise;
   logic               scl_fall;
   logic               start_det;
   logic               stop_det;

   hdf_sens_state_type state_reg;
   hdf_sens_state_type state_next;
   logic [3:0]         cnt_reg;
   logic [3:0]         cnt_next;
   logic [7:0]         sh_reg;
   logic [7:0]         sh_next;
   logic               rw_reg;
   logic               rw_next;
   logic               ack_reg;
   logic               ack_next;
   logic [2:0]         byte_reg;
   logic [2:0]         byte_next;
   logic [31:0]        snap_reg;
   logic [31:0]        snap_next;
   logic               drive_reg;
   logic               drive_next;
   logic               fresh_reg;
   logic               fresh_next;
   logic               pend_reg;
   logic               pend_next;
   logic               start_reg;
   logic               start_next;
   logic               busy_reg;
   logic               busy_next;
   hdf_code_type       hum_reg;
   hdf_code_type       hum_next;
   hdf_code_type       temp_reg;
   hdf_code_type       temp_next;
   logic [7:0]         first_byte;
   logic [7:0]         next_byte;

   // byte of the frozen snapshot; past the fourth the line stays released
   function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [2:0] idx);
      logic [7:0] b;
      b = `HDF_PAD_BYTE;
      case (idx)
         3'h0: b = w[31:24];
         3'h1: b = w[23:16];
         3'h2: b = w[15:8];
         3'h3: b = w[7:0];
         default: b = `HDF_PAD_BYTE;
      endcase
      return b;
   endfunction

   // pins come from another party: two flops before any logic reads them
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_s3_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_s3_reg <= 1'b1;
      end else begin
         scl_s1_reg <= LINK.scl;
         scl_s2_reg <= scl_s1_reg;
         scl_s3_reg <= scl_s2_reg;
         sda_s1_reg <= LINK.sda;
         sda_s2_reg <= sda_s1_reg;
         sda_s3_reg <= sda_s2_reg;
      end
   end

   assign scl_rise  = scl_s2_reg & ~scl_s3_reg;
   assign scl_fall  = ~scl_s2_reg & scl_s3_reg;
   assign start_det = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
   assign stop_det  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

   always_comb begin
      first_byte = pick_byte(snap_reg, 3'h0);
      next_byte  = pick_byte(snap_reg, byte_reg + 3'h1);
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      rw_next    = rw_reg;
      ack_next   = ack_reg;
      byte_next  = byte_reg;
      snap_next  = snap_reg;
      drive_next = drive_reg;
      fresh_next = fresh_reg;
      pend_next  = pend_reg;
      start_next = 1'b0;
      busy_next  = busy_reg;
      hum_next   = hum_reg;
      temp_next  = temp_reg;
      if (MEAS_DONE) begin
         hum_next   = HUM_CODE;
         temp_next  = TEMP_CODE;
         fresh_next = 1'b1;
         busy_next  = 1'b0;
      end
      case (state_reg)
         S_IDLE: begin
            drive_next = 1'b0;
         end
         S_ADDR: begin
            if (scl_rise) begin
               sh_next  = {sh_reg[6:0], sda_s2_reg};
               cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
               if (sh_reg[7:1] == `HDF_TARGET_ADDR) begin
                  drive_next = 1'b1;
                  rw_next    = sh_reg[0];
                  state_next = S_ACK;
                  if (sh_reg[0] == `HDF_DIR_READ) begin
                     // stale unless a measurement finished since the last fetch
                     snap_next = {fresh_reg ? `HDF_STAT_FRESH : `HDF_STAT_STALE,
                                  hum_reg, temp_reg, 2'h0};
                     // a completion in this very cycle keeps the flag set
                     fresh_next = MEAS_DONE;
                  end
               end else begin
                  state_next = S_IDLE;
               end
            end
         end
         S_ACK: begin
            if (scl_fall) begin
               if (rw_reg == `HDF_DIR_READ) begin
                  byte_next  = 3'h0;
                  cnt_next   = 4'h0;
                  drive_next = ~first_byte[7];
                  sh_next    = {first_byte[6:0], 1'b1};
                  state_next = S_TX;
               end else begin
                  drive_next = 1'b0;
                  pend_next  = 1'b1;
                  state_next = S_IDLE;
               end
            end
         end
         S_TX: begin
            if (scl_rise) begin
               cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall) begin
               if (cnt_reg == 4'h8) begin
                  drive_next = 1'b0;
                  state_next = S_RACK;
               end else begin
                  drive_next = ~sh_reg[7];
                  sh_next    = {sh_reg[6:0], 1'b1};
               end
            end
         end
         S_RACK: begin
            if (scl_rise) begin
               ack_next = ~sda_s2_reg;
            end else if (scl_fall) begin
               if (ack_reg) begin
                  // keep sending until the master refuses a byte
                  if (byte_reg != 3'h4) begin
                     byte_next = byte_reg + 3'h1;
                  end
                  cnt_next   = 4'h0;
                  drive_next = ~next_byte[7];
                  sh_next    = {next_byte[6:0], 1'b1};
                  state_next = S_TX;
               end else begin
                  drive_next = 1'b0;
                  state_next = S_IDLE;
               end
            end
         end
         default: begin
            drive_next = 1'b0;
            state_next = S_IDLE;
         end
      endcase
      if (start_det) begin
         drive_next = 1'b0;
         cnt_next   = 4'h0;
         state_next = S_ADDR;
      end else if (stop_det) begin
         drive_next = 1'b0;
         state_next = S_IDLE;
         if (pend_reg) begin
            // conversion begins only once the trigger frame is closed
            pend_next  = 1'b0;
            start_next = 1'b1;
            busy_next  = 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         state_reg <= S_IDLE;
         cnt_reg   <= 4'h0;
         sh_reg    <= 8'h00;
         rw_reg    <= 1'b0;
         ack_reg   <= 1'b0;
         byte_reg  <= 3'h0;
         snap_reg  <= 32'h00000000;
         drive_reg <= 1'b0;
         fresh_reg <= 1'b0;
         pend_reg  <= 1'b0;
         start_reg <= 1'b0;
         busy_reg  <= 1'b0;
         hum_reg   <= 14'h0000;
         temp_reg  <= 14'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         rw_reg    <= rw_next;
         ack_reg   <= ack_next;
         byte_reg  <= byte_next;
         snap_reg  <= snap_next;
         drive_reg <= drive_next;
         fresh_reg <= fresh_next;
         pend_reg  <= pend_next;
         start_reg <= start_next;
         busy_reg  <= busy_next;
         hum_reg   <= hum_next;
         temp_reg  <= temp_next;
      end
   end

   assign LINK.sda_s_out = 1'b0;
   assign LINK.sda_s_oe  = drive_reg;
   assign MEAS_START     = start_reg;
   assign MEAS_BUSY      = busy_reg;
   assign DATA_FRESH     = fresh_reg;
endmodule
`default_nettype wire

// [logic/hdf_master.sv]
// master end: issues conversion triggers and read-out fetches
`timescale 1ns/100ps
`default_nettype none
`include "hdf_regs.svh"
module hdf_master #(
   parameter int QUARTER_CYC = `HDF_QUARTER_CYC
) (
   input  wire logic                     SYS_CLK,
   input  wire logic                     RESET,
   hdf_if.master                         LINK,
   input  wire logic                     FETCH_REQ,
   input  wire logic                     FETCH_FULL,
   input  wire logic                     TRIG_REQ,
   output var  logic                     BUSY,
   output var  logic                     DONE,
   output var  logic                     ADDR_NACK,
   output var  hdf_pkg::hdf_status_type  STATUS,
   output var  logic                     DATA_VALID,
   output var  hdf_pkg::hdf_code_type    HUM_CODE,
   output var  hdf_pkg::hdf_code_type    TEMP_CODE,
   output var  logic [6:0]               HUM_PCT,
   output var  logic signed [7:0]        TEMP_DEG
);
   import hdf_pkg::*;

   logic               sda_s1_reg;
   logic               sda_s2_reg;
   hdf_mst_state_type  state_reg;
   hdf_mst_state_type  state_next;
   logic [15:0]        div_reg;
   logic [15:0]        div_next;
   logic [1:0]         q_reg;
   logic [1:0]         q_next;
   logic [2:0]         cnt_reg;
   logic [2:0]         cnt_next;
   logic [1:0]         nb_reg;
   logic [1:0]         nb_next;
   logic [7:0]         sh_reg;
   logic [7:0]         sh_next;
   logic [31:0]        rx_reg;
   logic [31:0]        rx_next;
   logic               rd_reg;
   logic               rd_next;
   logic               full_reg;
   logic               full_next;
   logic               smp_reg;
   logic               smp_next;
   logic               done_reg;
   logic               done_next;
   logic               nack_reg;
   logic               nack_next;
   hdf_status_type     stat_reg;
   hdf_status_type     stat_next;
   hdf_code_type       hum_reg;
   hdf_code_type       hum_next;
   hdf_code_type       temp_reg;
   hdf_code_type       temp_next;
   logic [6:0]         pct_reg;
   logic [6:0]         pct_next;
   logic signed [7:0]  deg_reg;
   logic signed [7:0]  deg_next;
   logic               scl_rel_reg;
   logic               scl_rel_next;
   logic               sda_rel_reg;
   logic               sda_rel_next;
   logic               tick;
   logic               last;
   logic [15:0]        hw;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
      end else begin
         sda_s1_reg <= LINK.sda;
         sda_s2_reg <= sda_s1_reg;
      end
   end

   assign tick = (div_reg == 16'(QUARTER_CYC - 1));
   assign last = full_reg ? (nb_reg == 2'h3) : (nb_reg == 2'h1);

   always_comb begin
      state_next = state_reg;
      div_next   = div_reg;
      q_next     = q_reg;
      cnt_next   = cnt_reg;
      nb_next    = nb_reg;
      sh_next    = sh_reg;
      rx_next    = rx_reg;
      rd_next    = rd_reg;
      full_next  = full_reg;
      smp_next   = smp_reg;
      done_next  = 1'b0;
      nack_next  = nack_reg;
      stat_next  = stat_reg;
      hum_next   = hum_reg;
      temp_next  = temp_reg;
      pct_next   = pct_reg;
      deg_next   = deg_reg;
      hw         = full_reg ? rx_reg[31:16] : rx_reg[15:0];
      if (state_reg == M_IDLE) begin
         div_next = 16'h0000;
         q_next   = 2'h0;
         if (FETCH_REQ || TRIG_REQ) begin
            // fetch wins when both ask in one cycle
            rd_next    = FETCH_REQ;
            full_next  = FETCH_FULL;
            sh_next    = {`HDF_TARGET_ADDR, FETCH_REQ ? `HDF_DIR_READ : `HDF_DIR_WRITE};
            nack_next  = 1'b0;
            state_next = M_START;
         end
      end else begin
         div_next = tick ? 16'h0000 : div_reg + 16'h0001;
         if (tick) begin
            q_next = q_reg + 2'h1;
            case (state_reg)
               M_START: begin
                  if (q_reg == 2'h3) begin
                     cnt_next   = 3'h0;
                     state_next = M_ADDR;
                  end
               end
               M_ADDR: begin
                  if (q_reg == 2'h3) begin
                     sh_next  = {sh_reg[6:0], 1'b0};
                     cnt_next = cnt_reg + 3'h1;
                     if (cnt_reg == 3'h7) begin
                        state_next = M_AACK;
                     end
                  end
               end
               M_AACK: begin
                  if (q_reg == 2'h2) begin
                     smp_next = sda_s2_reg;
                  end else if (q_reg == 2'h3) begin
                     cnt_next = 3'h0;
                     nb_next  = 2'h0;
                     if (smp_reg) begin
                        nack_next  = 1'b1;
                        state_next = M_STOP;
                     end else begin
                        state_next = rd_reg ? M_RDATA : M_STOP;
                     end
                  end
               end
               M_RDATA: begin
                  if (q_reg == 2'h2) begin
                     rx_next = {rx_reg[30:0], sda_s2_reg};
                  end else if (q_reg == 2'h3) begin
                     cnt_next = cnt_reg + 3'h1;
                     if (cnt_reg == 3'h7) begin
                        state_next = M_MACK;
                     end
                  end
               end
               M_MACK: begin
                  if (q_reg == 2'h3) begin
                     nb_next    = nb_reg + 2'h1;
                     cnt_next   = 3'h0;
                     state_next = last ? M_STOP : M_RDATA;
                  end
               end
               M_STOP: begin
                  if (q_reg == 2'h3) begin
                     done_next  = 1'b1;
                     state_next = M_IDLE;
                     if (rd_reg && !nack_reg) begin
                        stat_next = hw[15:14];
                        hum_next  = hw[13:0];
                        pct_next  = 7'((32'(hw[13:0]) * `HDF_HUM_SPAN) / `HDF_CODE_FULL);
                        if (full_reg) begin
                           temp_next = rx_reg[15:2];
                           deg_next  = 8'(((32'(rx_reg[15:2]) * `HDF_TEMP_SPAN) / `HDF_CODE_FULL)
                                          - `HDF_TEMP_OFS);
                        end
                     end
                  end
               end
               default: begin
                  state_next = M_IDLE;
               end
            endcase
         end
      end
   end

   // line levels for the current quarter of a bit
   always_comb begin
      scl_rel_next = 1'b1;
      sda_rel_next = 1'b1;
      case (state_reg)
         M_IDLE: begin
            scl_rel_next = 1'b1;
            sda_rel_next = 1'b1;
         end
         M_START: begin
            scl_rel_next = (q_reg != 2'h3);
            sda_rel_next = (q_reg == 2'h0);
         end
         M_STOP: begin
            scl_rel_next = (q_reg != 2'h0);
            sda_rel_next = (q_reg[1] == 1'b1);
         end
         M_ADDR: begin
            scl_rel_next = (q_reg == 2'h1) || (q_reg == 2'h2);
            sda_rel_next = sh_reg[7];
         end
         M_MACK: begin
            scl_rel_next = (q_reg == 2'h1) || (q_reg == 2'h2);
            sda_rel_next = last;
         end
         default: begin
            scl_rel_next = (q_reg == 2'h1) || (q_reg == 2'h2);
            sda_rel_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         state_reg   <= M_IDLE;
         div_reg     <= 16'h0000;
         q_reg       <= 2'h0;
         cnt_reg     <= 3'h0;
         nb_reg      <= 2'h0;
         sh_reg      <= 8'h00;
         rx_reg      <= 32'h00000000;
         rd_reg      <= 1'b0;
         full_reg    <= 1'b0;
         smp_reg     <= 1'b1;
         done_reg    <= 1'b0;
         nack_reg    <= 1'b0;
         stat_reg    <= `HDF_STAT_STALE;
         hum_reg     <= 14'h0000;
         temp_reg    <= 14'h0000;
         pct_reg     <= 7'h00;
         deg_reg     <= 8'h00;
         scl_rel_reg <= 1'b1;
         sda_rel_reg <= 1'b1;
      end else begin
         state_reg   <= state_next;
         div_reg     <= div_next;
         q_reg       <= q_next;
         cnt_reg     <= cnt_next;
         nb_reg      <= nb_next;
         sh_reg      <= sh_next;
         rx_reg      <= rx_next;
         rd_reg      <= rd_next;
         full_reg    <= full_next;
         smp_reg     <= smp_next;
         done_reg    <= done_next;
         nack_reg    <= nack_next;
         stat_reg    <= stat_next;
         hum_reg     <= hum_next;
         temp_reg    <= temp_next;
         pct_reg     <= pct_next;
         deg_reg     <= deg_next;
         scl_rel_reg <= scl_rel_next;
         sda_rel_reg <= sda_rel_next;
      end
   end

   assign LINK.scl_m_out = 1'b0;
   assign LINK.scl_m_oe  = ~scl_rel_reg;
   assign LINK.sda_m_out = 1'b0;
   assign LINK.sda_m_oe  = ~sda_rel_reg;
   assign BUSY           = (state_reg != M_IDLE);
   assign DONE           = done_reg;
   assign ADDR_NACK      = nack_reg;
   assign STATUS         = stat_reg;
   // codes 01, 10 and 11 all mean the data must be fetched again
   assign DATA_VALID     = (stat_reg == `HDF_STAT_FRESH);
   assign HUM_CODE       = hum_reg;
   assign TEMP_CODE      = temp_reg;
   assign HUM_PCT        = pct_reg;
   assign TEMP_DEG       = deg_reg;
endmodule
`default_nettype wire

// [testbench/hdf_link_asserts.sv]
// wire-level checks on the two-wire read-out link
`timescale 1ns/100ps
`default_nettype none
module hdf_link_asserts #(
   parameter int QUARTER_CYC = 4
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic scl_m_oe,
   input wire logic sda_m_oe,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   logic        scl_prev_reg, scl_prev_next;
   logic [15:0] run_reg, run_next;
   // run length of the current scl level, so low phases can be measured
   always_comb begin
      scl_prev_next = scl;
      run_next = (scl == scl_prev_reg) ? run_reg + 16'h1 : 16'h1;
   end
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         scl_prev_reg <= 1'b1;
         run_reg <= 16'h0;
      end else begin
         scl_prev_reg <= scl_prev_next;
         run_reg <= run_next;
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   AST_REL_AFTER_RESET: assert property (
      $fell(RESET) |-> !sda_s_oe && !sda_m_oe && !scl_m_oe) else $error("link held after reset");
   AST_SENS_LOW_ONLY: assert property (
      $changed(sda_s_oe) |-> !scl) else $error("sensor moved sda while scl high");
   AST_SENS_LAG: assert property (
      $fell(scl) |-> $stable(sda_s_oe)[*2]) else $error("sensor moved sda too early");
   AST_SENS_HOLD: assert property (
      $rose(scl) |=> $stable(sda_s_oe)[*7]) else $error("sensor bit not held");
   AST_SCL_LOW_RUN: assert property (
      scl && !scl_prev_reg |-> run_reg == 16'(2 * QUARTER_CYC)) else $error("scl low width");
   // open drain: a shared low is harmless, but a handover may overlap one low-clock cycle only
   AST_ONE_DRIVER: assert property (
      sda_s_oe && sda_m_oe |-> !scl ##1 !(sda_s_oe && sda_m_oe))
      else $error("both ends pull sda");
   AST_QUIET_AFTER_STOP: assert property (
      scl && $rose(sda) |=> (!sda_s_oe)[*4]) else $error("sensor drives after stop");
   AST_ACK_STANDS: assert property (
      $rose(sda_s_oe) |-> sda_s_oe[*8]) else $error("sensor low bit too short");
endmodule
`default_nettype wire

// [testbench/humidity_temp_data_fetch_bench.sv]
// self-checking bench: master and sensor joined over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module humidity_temp_data_fetch_bench;
   import hdf_pkg::*;
   localparam int QC = 4;
   logic              clk = 1'b0, rst = 1'b1, fetch_req = 1'b0, fetch_full = 1'b0;
   logic              trig_req = 1'b0, meas_done = 1'b0, meas_start, meas_busy;
   logic              data_fresh, busy, done, addr_nack, data_valid;
   hdf_code_type      hum_in = 14'h0, temp_in = 14'h0, hum_code, temp_code;
   hdf_status_type    status;
   logic [6:0]        hum_pct;
   logic signed [7:0] temp_deg;
   int                fail_count = 0, compares = 0, cycles = 0, starts = 0;
   hdf_if link ();
   hdf_master #(.QUARTER_CYC(QC)) u_hdf_master (.SYS_CLK(clk), .RESET(rst), .LINK(link),
      .FETCH_REQ(fetch_req), .FETCH_FULL(fetch_full), .TRIG_REQ(trig_req), .BUSY(busy),
      .DONE(done), .ADDR_NACK(addr_nack), .STATUS(status), .DATA_VALID(data_valid),
      .HUM_CODE(hum_code), .TEMP_CODE(temp_code), .HUM_PCT(hum_pct), .TEMP_DEG(temp_deg));
   hdf_sensor u_hdf_sensor (.SYS_CLK(clk), .RESET(rst), .LINK(link), .MEAS_START(meas_start),
      .MEAS_BUSY(meas_busy), .MEAS_DONE(meas_done), .HUM_CODE(hum_in), .TEMP_CODE(temp_in),
      .DATA_FRESH(data_fresh));
   hdf_link_asserts #(.QUARTER_CYC(QC)) u_hdf_link_asserts (.SYS_CLK(clk), .RESET(rst),
      .scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe),
      .scl(link.scl), .sda(link.sda));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic end_of_test();
      if (fail_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ceiling is well above the eight frames of the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (meas_start === 1'b1) starts <= starts + 1;
      if (cycles == 12000) begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic run(input logic trig, input logic full);
      int n;
      n = 0;
      fetch_req = !trig;
      trig_req = trig;
      fetch_full = full;
      tick(1);
      fetch_req = 1'b0;
      trig_req = 1'b0;
      chk(16'(busy), 16'h1, "request not taken");
      while (done !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk(16'(n < 2000), 16'h1, "no frame end");
      chk(16'(busy), 16'h0, "busy after frame end");
      chk(16'(addr_nack), 16'h0, "address refused");
   endtask
   task automatic measure(input hdf_code_type h, input hdf_code_type t);
      run(1'b1, 1'b0);
      tick(10);
      chk(16'(meas_busy), 16'h1, "not measuring");
      hum_in = h;
      temp_in = t;
      meas_done = 1'b1;
      tick(1);
      meas_done = 1'b0;
      chk(16'(data_fresh), 16'h1, "not fresh");
      chk(16'(meas_busy), 16'h0, "still measuring");
   endtask
   task automatic fetch(input logic full, input hdf_status_type st, input hdf_code_type h,
                        input hdf_code_type t);
      int p, d;
      p = int'(h) * 100 / 16383;
      d = int'(t) * 165 / 16383 - 40;
      run(1'b0, full);
      chk(16'(status), 16'(st), "status");
      chk(16'(data_valid), 16'(st == 2'h0), "valid");
      chk(16'(hum_code), 16'(h), "humidity");
      chk(16'(temp_code), 16'(t), "temperature");
      chk(16'(hum_pct), 16'(p), "percent");
      if (full) chk(16'(temp_deg), 16'(d), "degrees");
      chk(16'(data_fresh), 16'h0, "fresh after read");
   endtask
   initial begin
      tick(6);
      rst = 1'b0;
      // sensor sync flops need idle lines before the first start
      tick(4);
      chk(16'(data_fresh), 16'h0, "fresh at reset");
      fetch(1'b0, 2'h1, 14'h0, 14'h0);
      measure(14'h2abc, 14'h1f5b);
      fetch(1'b1, 2'h0, 14'h2abc, 14'h1f5b);
      fetch(1'b0, 2'h1, 14'h2abc, 14'h1f5b);
      measure(14'h3fff, 14'h0000);
      fetch(1'b1, 2'h0, 14'h3fff, 14'h0000);
      measure(14'h0000, 14'h3fff);
      fetch(1'b1, 2'h0, 14'h0000, 14'h3fff);
      chk(16'(starts), 16'h3, "trigger count");
      end_of_test();
   end
endmodule
`default_nettype wire
